// *** core/word_xfer_pkg.sv ***
// Purpose: Shared types and constants for the word transfer instruction unit
// Assumes: 16-bit words, linear register memory addressed by word
// Notes: Operation codes are one-hot encoded
package word_xfer_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 16;
  localparam int SIZE_W = 11;
  localparam logic [SIZE_W-1:0] TABLE_MIN = 11'h001;
  localparam logic [SIZE_W-1:0] TABLE_MAX = 11'h400;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
  localparam logic [SIZE_W-1:0] CNT_ZERO = 11'h000;
  localparam logic [SIZE_W-1:0] CNT_ONE = 11'h001;
  localparam logic [SIZE_W-1:0] CNT_TWO = 11'h002;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

  typedef enum logic [7:0] {
    OP_WORD_MOVE = 8'h01,
    OP_DOUBLE_WORD_MOVE = 8'h02,
    OP_INVERT_MOVE = 8'h04,
    OP_WORD_SWAP = 8'h08,
    OP_TABLE_FILL = 8'h10,
    OP_TABLE_COPY = 8'h20,
    OP_TABLE_INVERT_COPY = 8'h40,
    OP_INDEX_LOAD = 8'h80
  } xfer_op_t;

  typedef struct packed {
    xfer_op_t op;
    logic srcIsConst;
    logic [WORD_W-1:0] constVal;
    logic [ADDR_W-1:0] srcAddr;
    logic [ADDR_W-1:0] dstAddr;
    logic srcIndexed;
    logic dstIndexed;
    logic [SIZE_W-1:0] tableSize;
  } xfer_cmd_t;

  typedef struct packed {
    logic wrEn;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } mem_wr_t;
endpackage

// *** core/word_xfer_step.sv ***
// Purpose: Combinational step helper, computes word address and data transform
// Assumes: Used by the sequencer for every memory access it makes
// Notes: Address wraps modulo the memory size
`timescale 1ns/1ps
`default_nettype none
module word_xfer_step (
  input wire logic [word_xfer_pkg::ADDR_W-1:0] base,
  input wire logic [word_xfer_pkg::ADDR_W-1:0] offset,
  input wire logic [word_xfer_pkg::ADDR_W-1:0] indexVal,
  input wire logic useIndex,
  input wire logic [word_xfer_pkg::WORD_W-1:0] dataIn,
  input wire logic invert,
  output logic [word_xfer_pkg::ADDR_W-1:0] addr,
  output logic [word_xfer_pkg::WORD_W-1:0] dataOut
);
  import word_xfer_pkg::*;
  // Base plus optional index plus element offset
  always_comb
  begin
    addr = base + offset + (useIndex ? indexVal : ADDR_ZERO);
    dataOut = invert ? ~dataIn : dataIn;
  end
endmodule // word_xfer_step
`default_nettype wire

// *** core/word_xfer_unit.sv ***
// Purpose: Sequencer executing word, double-word, swap and table transfers
// Assumes: One-cycle-latency synchronous read port on the register memory
// Notes: One word moves per read/write pair; done pulses when finished
//
// How it works
// - Index load stores source word to index; indexed operand is base plus index.
// - Double-word move copies source pair into destination pair when enabled.
// - Double-word data is treated as full signed 32-bit, moved bit-exact.
// - Input off means no execution and output off; on executes, output on.
// - Inverted move writes complement of a register source word to destination; a constant source is written unchanged.
// - Table fill writes one source value into n consecutive destination words.
// - Table size must be 1 to 1024; otherwise nothing runs.
// - Table copy moves n consecutive source words to n destination words.
// - Overlapping copy picks its direction from the base addresses, so it stays correct unless only one operand is indexed.
// - Table invert copy writes complement of each register source word to destination; a constant source is written unchanged.
// - Pair holds upper half at base plus one, lower half at base.
// - Plain move stores register or constant source into destination.
`timescale 1ns/1ps
`default_nettype none
module word_xfer_unit (
  input wire logic mclk,
  input wire logic rst,
  input wire logic rungIn,
  input wire logic start,
  input wire word_xfer_pkg::xfer_cmd_t cmd,
  output logic rdEn,
  output logic [word_xfer_pkg::ADDR_W-1:0] rdAddr,
  input wire logic [word_xfer_pkg::WORD_W-1:0] rdData,
  output word_xfer_pkg::mem_wr_t memWr,
  output logic busy,
  output logic done,
  output logic rungOut,
  output logic sizeError,
  output logic [word_xfer_pkg::ADDR_W-1:0] indexOut
);
  import word_xfer_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_READ = 5'h02,
    ST_WAIT = 5'h04,
    ST_WRITE = 5'h08,
    ST_SWAP2 = 5'h10
  } state_t;

  state_t state_reg;
  xfer_cmd_t cmd_reg;
  logic [SIZE_W-1:0] count_reg;
  logic [SIZE_W-1:0] total_reg;
  logic descend_reg;
  logic [ADDR_W-1:0] srcOff;
  logic [ADDR_W-1:0] index_reg;
  logic [ADDR_W-1:0] elemOff;
  logic [ADDR_W-1:0] srcAddrW;
  logic [ADDR_W-1:0] dstAddrW;
  logic [WORD_W-1:0] xformData;
  logic invertSel;
  logic sizeOk;
  logic isTable;
  logic overlapDown;

  // Table ops need a legal size
  function automatic logic is_table_op(input xfer_op_t op);
    is_table_op = (op == OP_TABLE_FILL) || (op == OP_TABLE_COPY) ||
                  (op == OP_TABLE_INVERT_COPY);
  endfunction

  // Number of ST_WRITE passes each op makes; swap exchanges two words in one pass
  function automatic logic [SIZE_W-1:0] op_words(input xfer_cmd_t c);
    if (is_table_op(c.op))
      op_words = c.tableSize;
    else if (c.op == OP_DOUBLE_WORD_MOVE)
      op_words = CNT_TWO;
    else
      op_words = CNT_ONE;
  endfunction

  assign isTable = is_table_op(cmd.op);
  assign sizeOk = (cmd.tableSize >= TABLE_MIN) && (cmd.tableSize <= TABLE_MAX);
  // copy high to low when destination sits above an overlapping source
  assign overlapDown = (cmd.dstAddr > cmd.srcAddr);

  // Element offset follows the chosen direction
  always_comb
  begin
    if (descend_reg)
      elemOff = {{(ADDR_W-SIZE_W){1'b0}}, total_reg - CNT_ONE - count_reg};
    else
      elemOff = {{(ADDR_W-SIZE_W){1'b0}}, count_reg};
  end

  assign invertSel = (cmd_reg.op == OP_INVERT_MOVE) ||
                     (cmd_reg.op == OP_TABLE_INVERT_COPY);

  assign srcOff = (cmd_reg.op == OP_TABLE_FILL) ? ADDR_ZERO : elemOff;

  word_xfer_step srcStep (
    .base(cmd_reg.srcAddr),
    .offset(srcOff),
    .indexVal(index_reg),
    .useIndex(cmd_reg.srcIndexed),
    .dataIn(rdData),
    .invert(invertSel),
    .addr(srcAddrW),
    .dataOut(xformData)
  );

  word_xfer_step dstStep (
    .base(cmd_reg.dstAddr),
    .offset(elemOff),
    .indexVal(index_reg),
    .useIndex(cmd_reg.dstIndexed),
    .dataIn(WORD_ZERO),
    .invert(1'b0),
    .addr(dstAddrW),
    .dataOut()
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  // start only with rung on
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      cmd_reg <= '0;
      count_reg <= CNT_ZERO;
      total_reg <= CNT_ZERO;
      descend_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (start && rungIn && (!isTable || sizeOk))
          begin
            cmd_reg <= cmd;
            count_reg <= CNT_ZERO;
            total_reg <= op_words(cmd);
            descend_reg <= (cmd.op == OP_TABLE_COPY ||
                            cmd.op == OP_TABLE_INVERT_COPY) && overlapDown;
            if (cmd.srcIsConst && (cmd.op != OP_WORD_SWAP))
              state_reg <= ST_WRITE;
            else
              state_reg <= ST_READ;
          end
        end
        ST_READ:
          state_reg <= ST_WAIT;
        ST_WAIT:
        begin
          if (cmd_reg.op == OP_WORD_SWAP)
            state_reg <= ST_SWAP2;
          else
            state_reg <= ST_WRITE;
        end
        ST_SWAP2:
          state_reg <= ST_WRITE;
        ST_WRITE:
        begin
          if (count_reg + CNT_ONE >= total_reg)
            state_reg <= ST_IDLE;
          else
          begin
            count_reg <= count_reg + CNT_ONE;
            if (cmd_reg.srcIsConst)
              state_reg <= ST_WRITE;
            else
              state_reg <= ST_READ;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port and held word
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rdEn <= 1'b0;
      rdAddr <= ADDR_ZERO;
    end
    else
    begin
      rdEn <= 1'b0;
      if (state_reg == ST_READ)
      begin
        rdEn <= 1'b1;
        rdAddr <= srcAddrW;
      end
      else if (state_reg == ST_WAIT && cmd_reg.op == OP_WORD_SWAP)
      begin
        rdEn <= 1'b1;
        rdAddr <= dstAddrW;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write port
  always_ff @(posedge mclk)
  begin
    if (rst)
      memWr <= '0;
    else
    begin
      memWr.wrEn <= 1'b0;
      // first half of swap: destination gets source word
      if (state_reg == ST_SWAP2)
      begin
        memWr.wrEn <= 1'b1;
        memWr.addr <= dstAddrW;
        memWr.data <= rdData;
      end
      // second half of swap: source gets destination word
      else if (state_reg == ST_WRITE && cmd_reg.op == OP_WORD_SWAP)
      begin
        memWr.wrEn <= 1'b1;
        memWr.addr <= srcAddrW;
        memWr.data <= rdData;
      end
      else if (state_reg == ST_WRITE && cmd_reg.op != OP_INDEX_LOAD)
      begin
        // pair copied word by word, base then base plus one
        // complement applied by the step helper
        memWr.wrEn <= 1'b1;
        memWr.addr <= dstAddrW;
        memWr.data <= cmd_reg.srcIsConst ? cmd_reg.constVal : xformData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Index register
  // index load
  always_ff @(posedge mclk)
  begin
    if (rst)
      index_reg <= ADDR_ZERO;
    else if (state_reg == ST_WRITE && cmd_reg.op == OP_INDEX_LOAD)
      index_reg <= cmd_reg.srcIsConst ? cmd_reg.constVal : rdData;
  end

  ////////////////////////////////////////////////////////////////////////
  // Status outputs
  // rung output follows execution
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      rungOut <= 1'b0;
      sizeError <= 1'b0;
      indexOut <= ADDR_ZERO;
    end
    else
    begin
      done <= (state_reg == ST_WRITE) && (count_reg + CNT_ONE >= total_reg);
      busy <= (state_reg != ST_IDLE) &&
              !((state_reg == ST_WRITE) && (count_reg + CNT_ONE >= total_reg));
      indexOut <= index_reg;
      if (state_reg == ST_WRITE && count_reg + CNT_ONE >= total_reg)
        rungOut <= 1'b1;
      else if (state_reg == ST_IDLE && start)
        rungOut <= rungIn && (!isTable || sizeOk) ? rungOut : 1'b0;
      if (start && state_reg == ST_IDLE)
        sizeError <= rungIn && isTable && !sizeOk;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // off input never starts work
  AST_OFF_NO_RUN: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_IDLE && start && !rungIn) |=> state_reg == ST_IDLE)
    else $error("started with rung off");
  // bad size gives error, no run
  AST_SIZE_REJECT: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_IDLE && start && rungIn && isTable && !sizeOk)
    |=> (sizeError && state_reg == ST_IDLE))
    else $error("bad table size accepted");
  AST_INVERT: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_WAIT && cmd_reg.op == OP_INVERT_MOVE)
    |=> ##1 (memWr.wrEn && memWr.data == ~$past(rdData)))
    else $error("invert data wrong");
  AST_CONST_MOVE: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_IDLE && start && rungIn && cmd.op == OP_WORD_MOVE && cmd.srcIsConst)
    |=> ##1 (memWr.wrEn && memWr.data == $past(cmd.constVal, 2)))
    else $error("constant move wrong");
  AST_DOUBLE_TWO: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_IDLE && start && rungIn && cmd.op == OP_DOUBLE_WORD_MOVE && !cmd.srcIsConst)
    |-> ##[1:12] done)
    else $error("double move never finished");
  AST_DONE_OUT: assert property (@(posedge mclk) disable iff (rst)
    done |-> rungOut)
    else $error("done without output");
  // swap first write puts source word at destination
  AST_SWAP: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_SWAP2) |=> (memWr.wrEn && memWr.addr == $past(dstAddrW) &&
    memWr.data == $past(rdData)))
    else $error("swap write wrong");
  AST_INDEX: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_WRITE && cmd_reg.op == OP_INDEX_LOAD && cmd_reg.srcIsConst)
    |=> index_reg == $past(cmd_reg.constVal))
    else $error("index not loaded");
  // fill rereads the same source word
  AST_FILL_SRC: assert property (@(posedge mclk) disable iff (rst)
    (state_reg == ST_READ && cmd_reg.op == OP_TABLE_FILL && !cmd_reg.srcIndexed)
    |=> rdAddr == $past(cmd_reg.srcAddr))
    else $error("fill source address moved");
  COV_TABLE_COPY: cover property (@(posedge mclk) done && cmd_reg.op == OP_TABLE_COPY);
  COV_DESCEND: cover property (@(posedge mclk) done && descend_reg);
  COV_SWAP: cover property (@(posedge mclk) done && cmd_reg.op == OP_WORD_SWAP);
endmodule // word_xfer_unit
`default_nettype wire

// *** tb/tb_word_xfer_unit.sv ***
// Purpose: Self-checking bench for the word transfer sequencer
// Assumes: Register memory answers a read one cycle after rdEn
// Notes: Inputs change on the falling edge of mclk
`timescale 1ns/1ps
`default_nettype none
module tb_word_xfer_unit;
  import word_xfer_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic rungIn = 1'b0;
  logic start = 1'b0;
  xfer_cmd_t cmd = '0;
  logic rdEn;
  logic [ADDR_W-1:0] rdAddr;
  logic [WORD_W-1:0] rdData = WORD_ZERO;
  mem_wr_t memWr;
  logic busy, done, rungOut, sizeError;
  logic [ADDR_W-1:0] indexOut;
  logic [WORD_W-1:0] mem [0:65535];
  int n_mismatch = 0;
  int tests_run = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and design
  always #12.5 mclk = ~mclk;

  word_xfer_unit i_dut (.mclk(mclk), .rst(rst), .rungIn(rungIn), .start(start), .cmd(cmd),
    .rdEn(rdEn), .rdAddr(rdAddr), .rdData(rdData), .memWr(memWr), .busy(busy),
    .done(done), .rungOut(rungOut), .sizeError(sizeError), .indexOut(indexOut));

  // Linear word memory with a registered read port
  always @(posedge mclk)
  begin
    if (rdEn)
      rdData <= mem[rdAddr];
    if (memWr.wrEn)
      mem[memWr.addr] <= memWr.data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Issue one instruction; fl is {rung on, constant source, indexed operand}
  // A constant source has no address, so its index flag moves to the destination
  task automatic run(input xfer_op_t op, input logic [15:0] src, input logic [15:0] dst,
      input logic [10:0] n, input logic [15:0] k, input logic [2:0] fl);
    int cnt;
    logic ok;
    ok = fl[2] && (!(op == OP_TABLE_FILL || op == OP_TABLE_COPY ||
        op == OP_TABLE_INVERT_COPY) || (n >= TABLE_MIN && n <= TABLE_MAX));
    cmd.op = op;
    cmd.srcIsConst = fl[1];
    cmd.constVal = k;
    cmd.srcAddr = src;
    cmd.dstAddr = dst;
    cmd.srcIndexed = fl[0] & ~fl[1];
    cmd.dstIndexed = fl[0] & fl[1];
    cmd.tableSize = n;
    rungIn = fl[2];
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    cnt = 0;
    if (ok)
    begin
      while (done !== 1'b1 && cnt < 4000)
      begin
        @(negedge mclk);
        cnt++;
        if (done !== 1'b1)
          chk("busy", busy, 1);
      end
      chk("done", done, 1);
    end
    else
      repeat (6) @(negedge mclk);
    chk("rungOut", rungOut, ok);
    chk("busy idle", busy, 0);
    @(negedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_moves;
    run(OP_WORD_MOVE, 16'h0000, 16'h0100, TABLE_MIN, 16'h3039, 3'b110);
    chk("const move", mem[16'h0100], 16'h3039);
    mem[16'h0010] = 16'h01F4;
    run(OP_WORD_MOVE, 16'h0010, 16'h0020, TABLE_MIN, 16'h0000, 3'b100);
    chk("reg move", mem[16'h0020], 16'h01F4);
    mem[16'h0030] = 16'h4321;
    run(OP_INVERT_MOVE, 16'h0030, 16'h0040, TABLE_MIN, 16'h0000, 3'b100);
    chk("invert move", mem[16'h0040], 16'hBCDE);
  endtask

  task automatic t_double;
    mem[16'h0050] = 16'h0000;
    mem[16'h0051] = 16'h8000;
    run(OP_DOUBLE_WORD_MOVE, 16'h0050, 16'h0060, TABLE_MIN, 16'h0000, 3'b100);
    chk("pair", {mem[16'h0061], mem[16'h0060]}, 32'h80000000);
  endtask

  task automatic t_swap;
    mem[16'h0070] = 16'h5BA0;
    mem[16'h0071] = 16'h0123;
    run(OP_WORD_SWAP, 16'h0070, 16'h0071, TABLE_MIN, 16'h0000, 3'b100);
    chk("swap", {mem[16'h0070], mem[16'h0071]}, 32'h01235BA0);
  endtask

  task automatic t_tables;
    int i;
    mem[16'h0083] = 16'h0001;
    run(OP_TABLE_FILL, 16'h0000, 16'h0080, 11'h003, 16'hA5A5, 3'b110);
    chk("fill", {mem[16'h0080], mem[16'h0082]}, 32'hA5A5A5A5);
    chk("fill end", mem[16'h0083], 16'h0001);
    mem[16'h0090] = 16'h7E7E;
    run(OP_TABLE_FILL, 16'h0090, 16'h0091, 11'h003, 16'h0000, 3'b100);
    chk("fill reg", {mem[16'h0091], mem[16'h0092]}, 32'h7E7E7E7E);
    chk("fill reg end", mem[16'h0093], 16'h7E7E);
    for (i = 0; i < 1024; i++)
      mem[16'h1000 + i] = i[15:0];
    run(OP_TABLE_COPY, 16'h1000, 16'h1001, TABLE_MAX, 16'h0000, 3'b100);
    for (i = 0; i < 1024; i++)
      chk("copy up", mem[16'h1001 + i], i);
    for (i = 0; i < 5; i++)
      mem[16'h00A0 + i] = 16'h0010 + i[15:0];
    run(OP_TABLE_COPY, 16'h00A2, 16'h00A0, 11'h003, 16'h0000, 3'b100);
    chk("copy down", {mem[16'h00A0], mem[16'h00A2]}, 32'h00120014);
    mem[16'h00B0] = 16'h00FF;
    mem[16'h00B1] = 16'h1234;
    mem[16'h00B2] = 16'h89AB;
    run(OP_TABLE_INVERT_COPY, 16'h00B0, 16'h00C0, 11'h003, 16'h0000, 3'b100);
    chk("inv copy", {mem[16'h00C0], mem[16'h00C1]}, 32'hFF00EDCB);
    chk("inv copy end", mem[16'h00C2], 16'h7654);
  endtask

  task automatic t_index;
    mem[16'h0008] = 16'h012C;
    mem[16'h012D] = 16'hBEEF;
    run(OP_INDEX_LOAD, 16'h0008, 16'h0000, TABLE_MIN, 16'h0000, 3'b100);
    chk("index", indexOut, 16'h012C);
    run(OP_WORD_MOVE, 16'h0001, 16'h00D0, TABLE_MIN, 16'h0000, 3'b101);
    chk("indexed move", mem[16'h00D0], 16'hBEEF);
    run(OP_INDEX_LOAD, 16'h0000, 16'h0000, TABLE_MIN, 16'h0005, 3'b110);
    chk("const index", indexOut, 16'h0005);
    run(OP_WORD_MOVE, 16'h0000, 16'h00D8, TABLE_MIN, 16'h4444, 3'b111);
    chk("indexed dest", mem[16'h00DD], 16'h4444);
  endtask

  task automatic t_refuse;
    mem[16'h00E0] = 16'h1234;
    run(OP_WORD_MOVE, 16'h0000, 16'h00E0, TABLE_MIN, 16'h5678, 3'b010);
    chk("off move", mem[16'h00E0], 16'h1234);
    run(OP_TABLE_FILL, 16'h0000, 16'h00E0, CNT_ZERO, 16'h5678, 3'b110);
    chk("size 0", {sizeError, mem[16'h00E0]}, 17'h11234);
    run(OP_WORD_MOVE, 16'h0000, 16'h00F0, TABLE_MIN, 16'h0001, 3'b110);
    run(OP_TABLE_COPY, 16'h0000, 16'h00E0, 11'h401, 16'h0000, 3'b100);
    chk("size 1025", {sizeError, mem[16'h00E0]}, 17'h11234);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial
  begin
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    t_moves();
    t_double();
    t_swap();
    t_tables();
    t_index();
    t_refuse();
    end_sim();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    end_sim();
  end
endmodule // tb_word_xfer_unit
`default_nettype wire
